// *** logic/flash_status_write_protect.v ***
`include "flash_protect_map.vh"

// Overview of operation
// - Write Enable sets the write-enable latch, status bit S1.
// - Latch clears at power-up, Write Disable and every accepted write-type instruction.
// - Three range code bits S4..S2, changed only by status write; zero protects nothing, or the whole array when complement S14 is set.
// - Top/bottom bit anchors range at top when 0, bottom when 1.
// - Granularity bit selects 64KB blocks or 4KB sectors with 4/8/16/32KB ranges.
// - Code 000 none; block codes 64KB..512KB; 101 block and 11x whole array.
// - Complement bit S14 inverts protected and unprotected regions.
// - Program or erase touching any protected part is ignored.
// - Guard bits S8 and S7 choose the status register protection mode.
// - Guard 00: pin ignored, status writable whenever latch is set.
// - Guard 01: writes refused while protect pin low unless quad enable S9 is set, else need latch.
// - Guard 10: writes refused until power cycle, which returns guard to 00.
// - Guard 11: status register locked until reset, which returns guard to 00.
// - Suspend 75h sets paused flag S15; resume 7Ah or power cycle clears it.
// - Lock bits S13..S11 can be set but never cleared by a write, reset clears them; a set bit makes its security register read-only.
// - Quad enable S9 turns protect and pause pins into quad data lines.
// - Write-type instructions act only when select rises on a byte boundary.
// - Busy flag S0 reads 1 while program, erase or register write runs.
module flash_status_write_protect (
	input  wire        core_clk,
	input  wire        reset_n,
	input  wire        instr_valid,
	input  wire [7:0]  instr_code,
	input  wire [23:0] instr_addr,
	input  wire [15:0] instr_data,
	input  wire        instr_byte_aligned,
	input  wire        op_done,
	input  wire        write_protect_n,
	output wire [7:0]  status_low_byte,
	output wire [7:0]  status_high_byte,
	output reg         instr_accept,
	output reg         instr_reject,
	output wire        quad_enable,
	output wire [2:0]  security_read_only,
	output wire        pause_pin_enable
);

	// ==========================================================
	// Status state
	reg       write_enable_latch_q;
	reg       busy_q;
	reg       paused_op_flag_q;
	reg [2:0] range_code_q;
	reg       top_bottom_select_q;
	reg       small_unit_select_q;
	reg       complement_select_q;
	reg       sr_guard_upper_q;
	reg       sr_guard_lower_q;
	reg [2:0] security_lock_q;
	reg       quad_enable_q;

	// ==========================================================
	// Protect pin synchroniser; second and third stage must agree
	reg wp_s1_q;
	reg wp_s2_q;
	reg wp_s3_q;
	reg wp_level_q;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_s1_q    <= 1'b1;
			wp_s2_q    <= 1'b1;
			wp_s3_q    <= 1'b1;
			wp_level_q <= 1'b1;
		end else begin
			wp_s1_q <= write_protect_n;
			wp_s2_q <= wp_s1_q;
			wp_s3_q <= wp_s2_q;
			if (wp_s2_q == wp_s3_q)
				wp_level_q <= wp_s3_q;
		end
	end

	// ==========================================================
	// Instruction classification
	function is_array_write;
		input [7:0] code;
		begin
			case (code)
				`OP_PAGE_PROGRAM, `OP_QUAD_PROGRAM, `OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE,
				`OP_BLOCK_ERASE, `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
					is_array_write = 1'b1;
				default:
					is_array_write = 1'b0;
			endcase
		end
	endfunction

	function is_sec_write;
		input [7:0] code;
		begin
			is_sec_write = (code == `OP_SEC_ERASE) || (code == `OP_SEC_PROGRAM);
		end
	endfunction

	// ==========================================================
	// Addressed region in 4KB units
	reg [8:0] region_lo_d;
	reg [8:0] region_hi_d;

	always @* begin
		region_lo_d = {1'b0, instr_addr[19:12]};
		region_hi_d = {1'b0, instr_addr[19:12]};
		case (instr_code)
			`OP_HALF_BLOCK_ERASE: begin
				region_lo_d = {1'b0, instr_addr[19:15], 3'h0};
				region_hi_d = region_lo_d + `UNITS_HALF_BLOCK - 9'h001;
			end
			`OP_BLOCK_ERASE: begin
				region_lo_d = {1'b0, instr_addr[19:16], 4'h0};
				region_hi_d = region_lo_d + `UNITS_BLOCK - 9'h001;
			end
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
				region_lo_d = 9'h000;
				region_hi_d = `UNITS_ALL - 9'h001;
			end
			default: begin
				region_lo_d = {1'b0, instr_addr[19:12]};
				region_hi_d = {1'b0, instr_addr[19:12]};
			end
		endcase
	end

	wire region_protected;

	protect_range u_range (
		.small_unit_select (small_unit_select_q),
		.top_bottom_select (top_bottom_select_q),
		.complement_select (complement_select_q),
		.range_code        (range_code_q),
		.region_lo         (region_lo_d),
		.region_hi         (region_hi_d),
		.region_protected  (region_protected)
	);

	// ==========================================================
	// Acceptance conditions
	wire [1:0] guard_w = {sr_guard_upper_q, sr_guard_lower_q};
	reg        sr_writable_d;

	always @* begin
		case (guard_w)
			`GUARD_SOFTWARE:  sr_writable_d = 1'b1;
			// Quad mode takes the pin away from its protect function
			`GUARD_HARDWARE:  sr_writable_d = wp_level_q | quad_enable_q;
			`GUARD_LOCKDOWN:  sr_writable_d = 1'b0;
			`GUARD_PERMANENT: sr_writable_d = 1'b0;
			default:          sr_writable_d = 1'b0;
		endcase
	end

	// Security register index is taken from address bits 13:12, values 1 to 3
	wire [1:0] sec_index_w = instr_addr[13:12];
	wire       sec_valid_w = (sec_index_w != 2'h0);
	wire       sec_locked_w = sec_valid_w && security_lock_q[sec_index_w - 2'h1];

	// Write-type work needs the latch, an idle device and a byte boundary
	wire write_ok_w = write_enable_latch_q && !busy_q && instr_byte_aligned;

	wire wsr_go_w   = instr_valid && (instr_code == `OP_WRITE_STATUS) && write_ok_w && sr_writable_d;
	wire array_go_w = instr_valid && is_array_write(instr_code) && write_ok_w && !region_protected;
	wire sec_go_w   = instr_valid && is_sec_write(instr_code) && write_ok_w && sec_valid_w && !sec_locked_w;
	wire wren_go_w  = instr_valid && (instr_code == `OP_WRITE_ENABLE) && !busy_q;
	wire wrdi_go_w  = instr_valid && (instr_code == `OP_WRITE_DISABLE) && !busy_q;
	wire susp_go_w  = instr_valid && (instr_code == `OP_SUSPEND) && busy_q && !paused_op_flag_q;
	wire resm_go_w  = instr_valid && (instr_code == `OP_RESUME) && paused_op_flag_q && !busy_q;

	wire any_go_w   = wsr_go_w | array_go_w | sec_go_w | wren_go_w | wrdi_go_w | susp_go_w | resm_go_w;

	// ==========================================================
	// Status write data split into its fields
	wire [2:0] wr_range_w    = instr_data[`ST_RANGE_MSB:`ST_RANGE_LSB];
	wire       wr_tb_w       = instr_data[`ST_TB_BIT];
	wire       wr_sec_w      = instr_data[`ST_SEC_BIT];
	wire       wr_guard_lo_w = instr_data[`ST_GUARD_LO_BIT];
	wire       wr_guard_hi_w = instr_data[8 + `ST_GUARD_HI_BIT];
	wire       wr_qe_w       = instr_data[8 + `ST_QE_BIT];
	wire       wr_cmp_w      = instr_data[8 + `ST_CMP_BIT];
	wire [2:0] wr_lock_w     = instr_data[8 + `ST_LOCK_MSB:8 + `ST_LOCK_LSB];

	// ==========================================================
	// One-time lock cells: a write can only set them
	wire [2:0] lock_set_w;
	genvar     lock_i;

	generate
		for (lock_i = 0; lock_i < 3; lock_i = lock_i + 1) begin : g_lock_set
			assign lock_set_w[lock_i] = wsr_go_w & wr_lock_w[lock_i];
		end
	endgenerate

	// ==========================================================
	// Next values of the flags and the writable fields
	reg       write_enable_latch_d;
	reg       busy_d;
	reg       paused_op_flag_d;
	reg [2:0] range_code_d;
	reg       top_bottom_select_d;
	reg       small_unit_select_d;
	reg       complement_select_d;
	reg       sr_guard_upper_d;
	reg       sr_guard_lower_d;
	reg       quad_enable_d;
	reg [2:0] security_lock_d;

	always @* begin
		write_enable_latch_d = write_enable_latch_q;
		busy_d               = busy_q;
		paused_op_flag_d     = paused_op_flag_q;
		range_code_d         = range_code_q;
		top_bottom_select_d  = top_bottom_select_q;
		small_unit_select_d  = small_unit_select_q;
		complement_select_d  = complement_select_q;
		sr_guard_upper_d     = sr_guard_upper_q;
		sr_guard_lower_d     = sr_guard_lower_q;
		quad_enable_d        = quad_enable_q;
		// Lock bits only ever accumulate ones
		security_lock_d      = security_lock_q | lock_set_w;

		if (wren_go_w)
			write_enable_latch_d = 1'b1;
		else if (wrdi_go_w | wsr_go_w | array_go_w | sec_go_w)
			write_enable_latch_d = 1'b0;

		// Suspend parks the running operation so the array reads idle
		if (wsr_go_w | array_go_w | sec_go_w | resm_go_w)
			busy_d = 1'b1;
		else if (op_done | susp_go_w)
			busy_d = 1'b0;

		if (susp_go_w)
			paused_op_flag_d = 1'b1;
		else if (resm_go_w)
			paused_op_flag_d = 1'b0;

		if (wsr_go_w) begin
			range_code_d        = wr_range_w;
			top_bottom_select_d = wr_tb_w;
			small_unit_select_d = wr_sec_w;
			sr_guard_lower_d    = wr_guard_lo_w;
			sr_guard_upper_d    = wr_guard_hi_w;
			quad_enable_d       = wr_qe_w;
			complement_select_d = wr_cmp_w;
		end
	end

	// ==========================================================
	// Flag and field registers; reset stands in for the power cycle
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			write_enable_latch_q <= `RST_BIT;
			busy_q               <= `RST_BIT;
			paused_op_flag_q     <= `RST_BIT;
			range_code_q         <= `RST_RANGE;
			top_bottom_select_q  <= `RST_BIT;
			small_unit_select_q  <= `RST_BIT;
			complement_select_q  <= `RST_BIT;
			sr_guard_upper_q     <= `RST_BIT;
			sr_guard_lower_q     <= `RST_BIT;
			quad_enable_q        <= `RST_BIT;
			security_lock_q      <= `RST_LOCKS;
		end else begin
			write_enable_latch_q <= write_enable_latch_d;
			busy_q               <= busy_d;
			paused_op_flag_q     <= paused_op_flag_d;
			range_code_q         <= range_code_d;
			top_bottom_select_q  <= top_bottom_select_d;
			small_unit_select_q  <= small_unit_select_d;
			complement_select_q  <= complement_select_d;
			sr_guard_upper_q     <= sr_guard_upper_d;
			sr_guard_lower_q     <= sr_guard_lower_d;
			quad_enable_q        <= quad_enable_d;
			security_lock_q      <= security_lock_d;
		end
	end

	// ==========================================================
	// Answer pulses
	wire accept_d = any_go_w;
	wire reject_d = instr_valid && !any_go_w;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			instr_accept <= 1'b0;
			instr_reject <= 1'b0;
		end else begin
			instr_accept <= accept_d;
			instr_reject <= reject_d;
		end
	end

	// ==========================================================
	// Read-back; read-only flags never take write data
	assign status_low_byte = {sr_guard_lower_q, small_unit_select_q, top_bottom_select_q,
	                          range_code_q, write_enable_latch_q, busy_q};
	assign status_high_byte = {paused_op_flag_q, complement_select_q, security_lock_q,
	                           1'b0, quad_enable_q, sr_guard_upper_q};

	assign quad_enable        = quad_enable_q;
	assign pause_pin_enable   = !quad_enable_q;
	assign security_read_only = security_lock_q;

endmodule // flash_status_write_protect

// *** inc/flash_protect_map.vh ***
`ifndef FLASH_PROTECT_MAP_VH
`define FLASH_PROTECT_MAP_VH

// ==========================================================
// Instruction codes
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_WRITE_STATUS     8'h01
`define OP_PAGE_PROGRAM     8'h02
`define OP_QUAD_PROGRAM     8'h32
`define OP_SECTOR_ERASE     8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE      8'hD8
`define OP_CHIP_ERASE_A     8'hC7
`define OP_CHIP_ERASE_B     8'h60
`define OP_SUSPEND          8'h75
`define OP_RESUME           8'h7A
`define OP_SEC_ERASE        8'h44
`define OP_SEC_PROGRAM      8'h42

// ==========================================================
// Status low byte field positions
`define ST_BUSY_BIT         0
`define ST_WEL_BIT          1
`define ST_RANGE_LSB        2
`define ST_RANGE_MSB        4
`define ST_TB_BIT           5
`define ST_SEC_BIT          6
`define ST_GUARD_LO_BIT     7

// ==========================================================
// Status high byte field positions (bit index within the byte)
`define ST_GUARD_HI_BIT     0
`define ST_QE_BIT           1
`define ST_LOCK_LSB         3
`define ST_LOCK_MSB         5
`define ST_CMP_BIT          6
`define ST_PAUSED_BIT       7

// ==========================================================
// Factory values
`define RST_RANGE           3'h0
`define RST_GUARD           2'h0
`define RST_LOCKS           3'h0
`define RST_BIT             1'b0

// ==========================================================
// Array geometry in 4KB units
`define UNITS_ALL           9'h100
`define UNITS_HALF_BLOCK    9'h008
`define UNITS_BLOCK         9'h010

// ==========================================================
// Guard modes
`define GUARD_SOFTWARE      2'h0
`define GUARD_HARDWARE      2'h1
`define GUARD_LOCKDOWN      2'h2
`define GUARD_PERMANENT     2'h3

`endif

// *** logic/protect_range.v ***
`include "flash_protect_map.vh"

module protect_range (
	input  wire       small_unit_select,
	input  wire       top_bottom_select,
	input  wire       complement_select,
	input  wire [2:0] range_code,
	input  wire [8:0] region_lo,
	input  wire [8:0] region_hi,
	output wire       region_protected
);

	// ==========================================================
	// Length of the selected range in 4KB units
	function [8:0] range_units;
		input       sec;
		input [2:0] code;
		begin
			if (code == 3'h0)
				range_units = 9'h000;
			else if (sec) begin
				case (code)
					3'h1:    range_units = 9'h001;
					3'h2:    range_units = 9'h002;
					3'h3:    range_units = 9'h004;
					3'h4,
					3'h5:    range_units = 9'h008;
					default: range_units = `UNITS_ALL;
				endcase
			end else begin
				case (code)
					3'h1:    range_units = 9'h010;
					3'h2:    range_units = 9'h020;
					3'h3:    range_units = 9'h040;
					3'h4:    range_units = 9'h080;
					default: range_units = `UNITS_ALL;
				endcase
			end
		end
	endfunction

	wire [8:0] len_w     = range_units(small_unit_select, range_code);
	wire [8:0] sel_lo_w  = top_bottom_select ? 9'h000 : (`UNITS_ALL - len_w);
	wire [8:0] sel_hi_w  = top_bottom_select ? (len_w - 9'h001) : (`UNITS_ALL - 9'h001);
	wire       empty_w   = (len_w == 9'h000);
	wire       overlap_w = !empty_w && (region_lo <= sel_hi_w) && (region_hi >= sel_lo_w);
	wire       inside_w  = !empty_w && (region_lo >= sel_lo_w) && (region_hi <= sel_hi_w);

	// Complement: anything outside the selected range is protected
	assign region_protected = complement_select ? !inside_w : overlap_w;

endmodule // protect_range

// *** sim/flash_status_write_protect_chk.sv ***
// ==========
// Checker on the status and protection ports
module flash_status_write_protect_chk (
	input wire       core_clk,
	input wire       reset_n,
	input wire       instr_valid,
	input wire [7:0] instr_code,
	input wire       instr_byte_aligned,
	input wire       op_done,
	input wire [7:0] status_low_byte,
	input wire [7:0] status_high_byte,
	input wire       instr_accept,
	input wire       instr_reject,
	input wire       quad_enable,
	input wire       pause_pin_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Idle device only: busy refuses nearly everything
	sequence op_taken(c);
		instr_valid && instr_code == c && !status_low_byte[0];
	endsequence
	one_answer_a: assert property ((instr_accept || instr_reject) == $past(instr_valid) && !(instr_accept && instr_reject))
		else $error("answer not one per instruction");
	wel_set_a: assert property (op_taken(8'h06) |=> instr_accept && status_low_byte[1]) else $error("latch not set");
	wel_clear_a: assert property (op_taken(8'h04) |=> !status_low_byte[1]) else $error("latch not cleared");
	odd_bits_a: assert property (op_taken(8'h01) ##0 !instr_byte_aligned |=> instr_reject && $stable(status_low_byte))
		else $error("partial byte write taken");
	no_latch_a: assert property (op_taken(8'h01) ##0 !status_low_byte[1] |=> instr_reject) else $error("write without latch");
	guard_lock_a: assert property (op_taken(8'h01) ##0 status_high_byte[0] |=> instr_reject) else $error("guarded write taken");
	wrsr_ok_a: assert property (op_taken(8'h01) ##0 (status_low_byte[1] && instr_byte_aligned && !status_high_byte[0] &&
		!status_low_byte[7]) |=> instr_accept && status_low_byte[1:0] == 2'b01) else $error("status write lost");
	lock_keep_a: assert property (($past(status_high_byte[5:3]) & ~status_high_byte[5:3]) == 3'h0) else $error("lock cleared");
	pin_mode_a: assert property (pause_pin_enable == !quad_enable && quad_enable == status_high_byte[1])
		else $error("pin mode mismatch");
	suspend_a: assert property (instr_valid && instr_code == 8'h75 && status_low_byte[0] && !status_high_byte[7]
		|=> instr_accept && status_high_byte[7] && !status_low_byte[0]) else $error("suspend lost");
	busy_end_a: assert property (op_done && !instr_valid |=> !status_low_byte[0]) else $error("busy stuck");
endmodule // flash_status_write_protect_chk

bind flash_status_write_protect flash_status_write_protect_chk chk_i (.core_clk, .reset_n, .instr_valid, .instr_code,
	.instr_byte_aligned, .op_done, .status_low_byte, .status_high_byte, .instr_accept, .instr_reject, .quad_enable,
	.pause_pin_enable);

// *** sim/flash_host_model.sv ***
// ==========
// Host side: instruction presenter and execution done
module flash_host_model (
	input  wire        core_clk,
	input  wire        instr_accept,
	output reg         instr_valid,
	output reg  [7:0]  instr_code,
	output reg  [23:0] instr_addr,
	output reg  [15:0] instr_data,
	output reg         instr_byte_aligned,
	output reg         op_done,
	output reg         write_protect_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{instr_valid, instr_code, instr_addr, instr_data, instr_byte_aligned, op_done} = '0;
		write_protect_n = 1'b1;
	end
	task send(input [7:0] c, input [23:0] a, input [15:0] d, input al, output acc);
		@(posedge core_clk);
		#1 {instr_valid, instr_code, instr_addr, instr_data, instr_byte_aligned} = {1'b1, c, a, d, al};
		@(posedge core_clk);
		#1 acc = instr_accept;
		// Stale fields inverted so nothing leans on old values
		{instr_valid, instr_code, instr_addr, instr_data, instr_byte_aligned} = {1'b0, ~c, ~a, ~d, ~al};
	endtask
	task done;
		@(posedge core_clk);
		#1 op_done = 1'b1;
		@(posedge core_clk);
		#1 op_done = 1'b0;
	endtask
	// Pin is synchronised: give it time to land
	task set_wp(input v);
		@(posedge core_clk);
		#1 write_protect_n = v;
		repeat (6) @(posedge core_clk);
	endtask
endmodule // flash_host_model

// *** sim/flash_status_write_protect_test.sv ***
module flash_status_write_protect_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk;
	logic        reset_n = 1'b0;
	logic        acc;
	wire         instr_valid, instr_byte_aligned, op_done, write_protect_n, instr_accept, quad_enable, pause_pin_enable;
	wire         instr_reject;
	wire [7:0]   instr_code, status_low_byte, status_high_byte;
	wire [23:0]  instr_addr;
	wire [15:0]  instr_data;
	wire [2:0]   security_read_only;
	wire [15:0]  st = {status_high_byte, status_low_byte};
	integer      fails = 0;
	integer      n_tests = 0;
	logic [40:0] tbl [0:14] = '{{16'h0004, 24'h0F_0000, 1'b0}, {16'h0004, 24'h0E_F000, 1'b1}, {16'h0024, 24'h00_0000, 1'b0},
		{16'h0024, 24'h01_0000, 1'b1}, {16'h0044, 24'h0F_F000, 1'b0}, {16'h0044, 24'h0F_E000, 1'b1},
		{16'h0050, 24'h0F_8000, 1'b0}, {16'h0050, 24'h0F_7000, 1'b1}, {16'h0010, 24'h08_0000, 1'b0},
		{16'h0010, 24'h07_F000, 1'b1}, {16'h0014, 24'h00_0000, 1'b0}, {16'h0018, 24'h00_0000, 1'b0},
		{16'h4004, 24'h0F_0000, 1'b1}, {16'h4004, 24'h0E_F000, 1'b0}, {16'h0000, 24'h0F_F000, 1'b1}};
	flash_status_write_protect dut (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
		.instr_code(instr_code), .instr_addr(instr_addr), .instr_data(instr_data),
		.instr_byte_aligned(instr_byte_aligned), .op_done(op_done), .write_protect_n(write_protect_n),
		.status_low_byte(status_low_byte), .status_high_byte(status_high_byte), .instr_accept(instr_accept),
		.instr_reject(instr_reject), .quad_enable(quad_enable), .security_read_only(security_read_only),
		.pause_pin_enable(pause_pin_enable));
	flash_host_model host (.core_clk(core_clk), .instr_accept(instr_accept), .instr_valid(instr_valid),
		.instr_code(instr_code), .instr_addr(instr_addr), .instr_data(instr_data),
		.instr_byte_aligned(instr_byte_aligned), .op_done(op_done), .write_protect_n(write_protect_n));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task chk(input string what, input [15:0] e, input [15:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task op(input [7:0] c, input [23:0] a, input [15:0] d, input e);
		host.send(c, a, d, 1'b1, acc);
		chk("accept", {15'h0000, e}, {15'h0000, acc});
		chk("reject", {15'h0000, ~e}, {15'h0000, instr_reject});
	endtask
	// Always enables first: hosts must, or the write is refused
	task wrsr(input [15:0] d);
		op(8'h06, 24'h00_0000, 16'h0000, 1'b1);
		op(8'h01, 24'h00_0000, d, 1'b1);
		host.done;
	endtask
	task do_reset;
		@(posedge core_clk);
		#1 reset_n = 1'b0;
		repeat (5) @(posedge core_clk);
		#1 reset_n = 1'b1;
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fails = fails + 1;
		stop_test;
	end
	initial begin
		do_reset;
		chk("status", 16'h0000, st);
		op(8'h06, 0, 0, 1'b1);
		chk("status", 16'h0002, st);
		op(8'h04, 0, 0, 1'b1);
		chk("status", 16'h0000, st);
		op(8'h01, 0, 16'h0004, 1'b0);
		op(8'h06, 0, 0, 1'b1);
		host.send(8'h01, 0, 16'h0004, 1'b0, acc);
		chk("status", 16'h0002, st);
		op(8'h01, 0, 16'h0004, 1'b1);
		chk("status", 16'h0005, st);
		host.done;
		chk("status", 16'h0004, st);
		$display("test latch done");
		for (int i = 0; i < 15; i++) begin
			wrsr(tbl[i][40:25]);
			op(8'h06, 0, 0, 1'b1);
			op(8'h20, tbl[i][24:1], 0, tbl[i][0]);
			if (tbl[i][0]) host.done;
		end
		$display("test ranges done");
		wrsr(16'h0044);
		op(8'h06, 0, 0, 1'b1);
		op(8'h52, 24'h0F_8000, 0, 1'b0);
		op(8'h02, 24'h0F_F0FF, 0, 1'b0);
		op(8'hC7, 0, 0, 1'b0);
		op(8'h52, 24'h0F_0000, 0, 1'b1);
		host.done;
		op(8'h06, 0, 0, 1'b1);
		op(8'h32, 24'h0F_E000, 0, 1'b1);
		host.done;
		wrsr(16'h0004);
		op(8'h06, 0, 0, 1'b1);
		op(8'hD8, 24'h0F_8000, 0, 1'b0);
		op(8'hD8, 24'h0E_F000, 0, 1'b1);
		host.done;
		wrsr(16'h0000);
		op(8'h06, 0, 0, 1'b1);
		op(8'h44, 24'h00_0000, 0, 1'b0);
		op(8'h44, 24'h00_2000, 0, 1'b1);
		chk("status", 16'h0001, st);
		host.done;
		op(8'h06, 0, 0, 1'b1);
		op(8'h60, 0, 0, 1'b1);
		host.done;
		$display("test regions done");
		op(8'h06, 0, 0, 1'b1);
		op(8'h20, 0, 0, 1'b1);
		op(8'h75, 0, 0, 1'b1);
		chk("status", 16'h8000, st);
		op(8'h7A, 0, 0, 1'b1);
		chk("status", 16'h0001, st);
		host.done;
		$display("test suspend done");
		wrsr(16'h0800);
		chk("locks", 16'h0001, {13'h0000, security_read_only});
		wrsr(16'h0000);
		chk("status", 16'h0800, st);
		op(8'h06, 0, 0, 1'b1);
		op(8'h42, 24'h00_1000, 0, 1'b0);
		wrsr(16'h0A00);
		chk("pins", 16'h0002, {14'h0000, quad_enable, pause_pin_enable});
		wrsr(16'h0880);
		chk("status", 16'h0880, st);
		host.set_wp(1'b0);
		op(8'h06, 0, 0, 1'b1);
		op(8'h01, 0, 16'h0800, 1'b0);
		host.set_wp(1'b1);
		op(8'h01, 0, 16'h0800, 1'b1);
		host.done;
		wrsr(16'h0A80);
		host.set_wp(1'b0);
		op(8'h06, 0, 0, 1'b1);
		op(8'h01, 0, 16'h0800, 1'b1);
		host.done;
		host.set_wp(1'b1);
		wrsr(16'h0900);
		op(8'h06, 0, 0, 1'b1);
		op(8'h01, 0, 16'h0000, 1'b0);
		chk("status", 16'h0902, st);
		do_reset;
		chk("status", 16'h0000, st);
		wrsr(16'h0180);
		op(8'h06, 0, 0, 1'b1);
		op(8'h01, 0, 16'h0000, 1'b0);
		chk("status", 16'h0182, st);
		$display("test guards done");
		stop_test;
	end
endmodule // flash_status_write_protect_test
